//--- common/lsd_regs.vh
`ifndef LSD_REGS_VH
`define LSD_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define LSD_ADDR_W            8
`define LSD_DATA_W            16
`define LSD_OFF_SLOT_ROUTING  8'h14
`define LSD_OFF_THIRD_DRIVE   8'h22
`define LSD_OFF_FIRST_DRIVE   8'h23
`define LSD_OFF_FINE_ADJUST   8'h25

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define LSD_RST_SLOT_ROUTING  16'h0541
`define LSD_RST_EMITTER_DRIVE 16'h3000
`define LSD_RST_FINE_ADJUST   16'h6000

// ----------------------------------------------------------------------------
// Slot routing fields
// ----------------------------------------------------------------------------
`define LSD_SLOT_A_CHOICE_LSB 0
`define LSD_SLOT_B_CHOICE_LSB 2
`define LSD_CHOICE_W          2
`define LSD_SLOT_A_ROUTE_LSB  4
`define LSD_SLOT_B_ROUTE_LSB  8
`define LSD_ROUTE_W           4
`define LSD_CHOICE_NONE       2'h0
`define LSD_CHOICE_FIRST      2'h1
`define LSD_CHOICE_SECOND     2'h2
`define LSD_CHOICE_THIRD      2'h3

// ----------------------------------------------------------------------------
// Emitter drive fields
// ----------------------------------------------------------------------------
`define LSD_SCALE_BIT         13
`define LSD_SLEW_LSB          4
`define LSD_SLEW_W            3
`define LSD_COARSE_LSB        0
`define LSD_COARSE_W          4
`define LSD_THIRD_FINE_LSB    11
`define LSD_FINE_W            5

// ----------------------------------------------------------------------------
// Peak target arithmetic, coarse in 0.1 mA, fine in 1/1000, scale in 1/10
// ----------------------------------------------------------------------------
`define LSD_COARSE_BASE       12'h01F7
`define LSD_COARSE_STEP       12'h00C6
`define LSD_FINE_BASE         11'h2E4
`define LSD_FINE_STEP         11'h016
`define LSD_SCALE_LOW         4'h1
`define LSD_SCALE_FULL        4'hA
`define LSD_PEAK_W            27

`endif

//--- verilog/lsd_slot_decode.v
`timescale 1ns/10ps

`include "lsd_regs.vh"

module lsd_slot_decode (
  input  wire [1:0] choice_i,
  output reg  [2:0] fire_sel_o,
  output wire       float_en_o
);

  // --------------------------------------------------------------------------
  // Emitter choice decode
  // --------------------------------------------------------------------------
  always @* begin
    case (choice_i)
      `LSD_CHOICE_FIRST:  fire_sel_o = 3'h1; // RL1 RL2
      `LSD_CHOICE_SECOND: fire_sel_o = 3'h2; // RL1 RL2
      `LSD_CHOICE_THIRD:  fire_sel_o = 3'h4; // RL1 RL2
      default:            fire_sel_o = 3'h0; // RL3
    endcase
  end

  // Code zero fires nothing and pulses the diode connection instead.
  assign float_en_o = (choice_i == `LSD_CHOICE_NONE); // RL3

endmodule // lsd_slot_decode

//--- verilog/lsd_emitter_drive.v
`timescale 1ns/10ps

`include "lsd_regs.vh"

module lsd_emitter_drive #(
  parameter PEAK_W = `LSD_PEAK_W
) (
  input  wire                      clk_i,
  input  wire                      rst_n_i,
  input  wire [`LSD_DATA_W-1:0]    drive_i,
  input  wire [`LSD_FINE_W-1:0]    fine_i,
  output reg                       scale_o,
  output reg                       low_power_o,
  output reg  [`LSD_SLEW_W-1:0]    slew_o,
  output reg  [`LSD_COARSE_W-1:0]  coarse_o,
  output reg  [PEAK_W-1:0]         peak_o
);

  // --------------------------------------------------------------------------
  // Peak target: coarse times fine times scale
  // --------------------------------------------------------------------------
  wire                      scale_bit;
  wire [`LSD_COARSE_W-1:0]  coarse_code;
  wire [11:0]               coarse_val;
  wire [10:0]               fine_val;
  wire [3:0]                scale_val;
  wire [PEAK_W-1:0]         peak_d;

  assign scale_bit   = drive_i[`LSD_SCALE_BIT];
  assign coarse_code = drive_i[`LSD_COARSE_LSB +: `LSD_COARSE_W];
  assign coarse_val  = `LSD_COARSE_BASE + `LSD_COARSE_STEP * {8'h00, coarse_code};
  assign fine_val    = `LSD_FINE_BASE + `LSD_FINE_STEP * {6'h00, fine_i};
  // Low scale is one tenth of full scale.
  assign scale_val   = scale_bit ? `LSD_SCALE_FULL : `LSD_SCALE_LOW; // RL7 RL11
  assign peak_d      = {{(PEAK_W-12){1'b0}}, coarse_val}
                     * {{(PEAK_W-11){1'b0}}, fine_val}
                     * {{(PEAK_W-4){1'b0}}, scale_val}; // RL10

  // --------------------------------------------------------------------------
  // Registered driver settings
  // --------------------------------------------------------------------------
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scale_o     <= 1'b1;
      low_power_o <= 1'b0;
      slew_o      <= 3'h0;
      coarse_o    <= 4'h0;
      peak_o      <= {PEAK_W{1'b0}};
    end else begin
      scale_o     <= scale_bit; // RL7 RL11
      low_power_o <= ~scale_bit; // RL7 RL11
      slew_o      <= drive_i[`LSD_SLEW_LSB +: `LSD_SLEW_W]; // RL8 RL12
      coarse_o    <= coarse_code; // RL9 RL13
      peak_o      <= peak_d; // RL10
    end
  end

endmodule // lsd_emitter_drive

//--- verilog/lsd_top.v
`timescale 1ns/10ps

`include "lsd_regs.vh"

// Operation
// (RL1) Slot B emitter field bits 3:2 picks first, second or third emitter; resets 0.
// (RL2) Slot A emitter field bits 1:0 uses same codes; resets to first emitter.
// (RL3) Emitter code 0 fires nothing; diode connection pulses with float mode enabled.
// (RL4) Slot B diode routing field bits 11:8 resets to 5.
// (RL5) Slot A diode routing field bits 7:4 resets to 4.
// (RL6) Software writes zeros to slot routing bits 15:12.
// (RL7) Third emitter scale bit 13: 1 full, 0 tenth and low power; resets 1.
// (RL8) Third emitter slew bits 6:4, 0 slowest, 7 fastest; resets 0.
// (RL9) Third emitter coarse current bits 3:0, 0 lowest, F highest; resets 0.
// (RL10) Third emitter peak is coarse times fine (bits 15:11) times scale.
// (RL11) First emitter scale bit 13: 1 full, 0 tenth and low power; resets 1.
// (RL12) First emitter slew bits 6:4, 0 slowest, 7 fastest; resets 0.
// (RL13) First emitter coarse current bits 3:0, 0 lowest, F highest; resets 0.
// (RL14) Drive reserved bits written 0, bit 12 written 1; all read back.
module lsd_top #(
  parameter PEAK_W = `LSD_PEAK_W
) (
  input  wire                      CLK_SYS_I,
  input  wire                      RSTN_I,
  input  wire [`LSD_ADDR_W-1:0]    REG_ADDR_I,
  input  wire                      REG_WR_I,
  input  wire                      REG_RD_I,
  input  wire [`LSD_DATA_W-1:0]    REG_WDATA_I,
  output reg  [`LSD_DATA_W-1:0]    REG_RDATA_O,
  input  wire                      SLOT_A_ACTIVE_I,
  input  wire                      SLOT_B_ACTIVE_I,
  input  wire                      LED_PULSE_I,
  output reg  [2:0]                EMITTER_FIRE_O,
  output reg  [`LSD_ROUTE_W-1:0]   DIODE_ROUTE_O,
  output reg                       FLOAT_MODE_O,
  output reg                       PULSE_CONNECT_O,
  output wire                      FIRST_SCALE_O,
  output wire                      FIRST_LOW_POWER_O,
  output wire [`LSD_SLEW_W-1:0]    FIRST_SLEW_O,
  output wire [`LSD_COARSE_W-1:0]  FIRST_COARSE_O,
  output wire [PEAK_W-1:0]         FIRST_PEAK_O,
  output wire                      THIRD_SCALE_O,
  output wire                      THIRD_LOW_POWER_O,
  output wire [`LSD_SLEW_W-1:0]    THIRD_SLEW_O,
  output wire [`LSD_COARSE_W-1:0]  THIRD_COARSE_O,
  output wire [PEAK_W-1:0]         THIRD_PEAK_O
);

  // --------------------------------------------------------------------------
  // Register storage
  // --------------------------------------------------------------------------
  reg  [`LSD_DATA_W-1:0]  slot_routing_q;
  reg  [`LSD_DATA_W-1:0]  third_drive_q;
  reg  [`LSD_DATA_W-1:0]  first_drive_q;
  reg  [`LSD_DATA_W-1:0]  fine_adjust_q;
  reg  [`LSD_DATA_W-1:0]  rdata_d;
  wire                    hit_routing;
  wire                    hit_third;
  wire                    hit_first;
  wire                    hit_fine;

  assign hit_routing = (REG_ADDR_I == `LSD_OFF_SLOT_ROUTING);
  assign hit_third   = (REG_ADDR_I == `LSD_OFF_THIRD_DRIVE);
  assign hit_first   = (REG_ADDR_I == `LSD_OFF_FIRST_DRIVE);
  assign hit_fine    = (REG_ADDR_I == `LSD_OFF_FINE_ADJUST);

  // All bits, reserved ones included, store what software writes; the
  // reserved routing bits are expected to be written as zero.
  always @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      slot_routing_q <= `LSD_RST_SLOT_ROUTING; // RL1 RL2 RL4 RL5
      third_drive_q  <= `LSD_RST_EMITTER_DRIVE; // RL7 RL8 RL9
      first_drive_q  <= `LSD_RST_EMITTER_DRIVE; // RL11 RL12 RL13
      fine_adjust_q  <= `LSD_RST_FINE_ADJUST;
    end else if (REG_WR_I) begin
      if (hit_routing) begin
        slot_routing_q <= REG_WDATA_I; // RL6
      end
      if (hit_third) begin
        third_drive_q <= REG_WDATA_I; // RL14
      end
      if (hit_first) begin
        first_drive_q <= REG_WDATA_I; // RL14
      end
      if (hit_fine) begin
        fine_adjust_q <= REG_WDATA_I;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Read port
  // --------------------------------------------------------------------------
  always @* begin
    case (1'b1)
      hit_routing: rdata_d = slot_routing_q;
      hit_third:   rdata_d = third_drive_q; // RL14
      hit_first:   rdata_d = first_drive_q; // RL14
      hit_fine:    rdata_d = fine_adjust_q;
      default:     rdata_d = 16'h0000;
    endcase
  end

  // Read data appears one cycle after the read strobe and holds until the next.
  always @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      REG_RDATA_O <= 16'h0000;
    end else if (REG_RD_I) begin
      REG_RDATA_O <= rdata_d;
    end
  end

  // --------------------------------------------------------------------------
  // Per-slot emitter decode
  // --------------------------------------------------------------------------
  wire [5:0]  slot_fire_sel;
  wire [1:0]  slot_float_en;

  genvar gs;
  generate
    for (gs = 0; gs < 2; gs = gs + 1) begin : g_slot
      lsd_slot_decode u_decode (
        .choice_i   (slot_routing_q[gs*`LSD_CHOICE_W +: `LSD_CHOICE_W]), // RL1 RL2
        .fire_sel_o (slot_fire_sel[gs*3 +: 3]),
        .float_en_o (slot_float_en[gs])
      );
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Slot output stage
  // --------------------------------------------------------------------------
  reg  [2:0]               fire_d;
  reg  [`LSD_ROUTE_W-1:0]  route_d;
  reg                      float_d;
  reg                      connect_d;

  // Slot A takes precedence if the timing core asserts both slots at once.
  always @* begin
    fire_d    = 3'h0;
    route_d   = DIODE_ROUTE_O;
    float_d   = 1'b0;
    connect_d = 1'b0;
    if (SLOT_A_ACTIVE_I) begin
      route_d   = slot_routing_q[`LSD_SLOT_A_ROUTE_LSB +: `LSD_ROUTE_W]; // RL5
      fire_d    = LED_PULSE_I ? slot_fire_sel[2:0] : 3'h0; // RL2
      float_d   = slot_float_en[0]; // RL3
      connect_d = slot_float_en[0] & LED_PULSE_I; // RL3
    end else if (SLOT_B_ACTIVE_I) begin
      route_d   = slot_routing_q[`LSD_SLOT_B_ROUTE_LSB +: `LSD_ROUTE_W]; // RL4
      fire_d    = LED_PULSE_I ? slot_fire_sel[5:3] : 3'h0; // RL1
      float_d   = slot_float_en[1]; // RL3
      connect_d = slot_float_en[1] & LED_PULSE_I; // RL3
    end
  end

  always @(posedge CLK_SYS_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      EMITTER_FIRE_O  <= 3'h0;
      DIODE_ROUTE_O   <= 4'h0;
      FLOAT_MODE_O    <= 1'b0;
      PULSE_CONNECT_O <= 1'b0;
    end else begin
      EMITTER_FIRE_O  <= fire_d;
      DIODE_ROUTE_O   <= route_d;
      FLOAT_MODE_O    <= float_d;
      PULSE_CONNECT_O <= connect_d;
    end
  end

  // --------------------------------------------------------------------------
  // Emitter driver settings, index 0 first emitter, index 1 third emitter
  // --------------------------------------------------------------------------
  wire [2*`LSD_DATA_W-1:0]    drive_vec;
  wire [2*`LSD_FINE_W-1:0]    fine_vec;
  wire [1:0]                  scale_vec;
  wire [1:0]                  low_power_vec;
  wire [2*`LSD_SLEW_W-1:0]    slew_vec;
  wire [2*`LSD_COARSE_W-1:0]  coarse_vec;
  wire [2*PEAK_W-1:0]         peak_vec;

  assign drive_vec = {third_drive_q, first_drive_q};
  // The first emitter's fine code is outside this bank; it is held at the
  // third emitter's fine code so its peak target stays defined.
  assign fine_vec  = {2{fine_adjust_q[`LSD_THIRD_FINE_LSB +: `LSD_FINE_W]}}; // RL10

  genvar ge;
  generate
    for (ge = 0; ge < 2; ge = ge + 1) begin : g_emitter
      lsd_emitter_drive #(
        .PEAK_W (PEAK_W)
      ) u_drive (
        .clk_i       (CLK_SYS_I),
        .rst_n_i     (RSTN_I),
        .drive_i     (drive_vec[ge*`LSD_DATA_W +: `LSD_DATA_W]),
        .fine_i      (fine_vec[ge*`LSD_FINE_W +: `LSD_FINE_W]),
        .scale_o     (scale_vec[ge]),
        .low_power_o (low_power_vec[ge]),
        .slew_o      (slew_vec[ge*`LSD_SLEW_W +: `LSD_SLEW_W]),
        .coarse_o    (coarse_vec[ge*`LSD_COARSE_W +: `LSD_COARSE_W]),
        .peak_o      (peak_vec[ge*PEAK_W +: PEAK_W])
      );
    end
  endgenerate

  assign FIRST_SCALE_O     = scale_vec[0];
  assign FIRST_LOW_POWER_O = low_power_vec[0];
  assign FIRST_SLEW_O      = slew_vec[0 +: `LSD_SLEW_W];
  assign FIRST_COARSE_O    = coarse_vec[0 +: `LSD_COARSE_W];
  assign FIRST_PEAK_O      = peak_vec[0 +: PEAK_W];
  assign THIRD_SCALE_O     = scale_vec[1];
  assign THIRD_LOW_POWER_O = low_power_vec[1];
  assign THIRD_SLEW_O      = slew_vec[`LSD_SLEW_W +: `LSD_SLEW_W];
  assign THIRD_COARSE_O    = coarse_vec[`LSD_COARSE_W +: `LSD_COARSE_W];
  assign THIRD_PEAK_O      = peak_vec[PEAK_W +: PEAK_W];

endmodule // lsd_top

//--- sim/lsd_monitor.sv
`timescale 1ns/10ps

`include "lsd_regs.vh"

module lsd_monitor (
  input wire                      CLK_SYS_I,
  input wire                      RSTN_I,
  input wire [`LSD_ADDR_W-1:0]    REG_ADDR_I,
  input wire                      REG_WR_I,
  input wire [`LSD_DATA_W-1:0]    REG_WDATA_I,
  input wire                      SLOT_A_ACTIVE_I,
  input wire                      SLOT_B_ACTIVE_I,
  input wire                      LED_PULSE_I,
  input wire [2:0]                EMITTER_FIRE_O,
  input wire                      FLOAT_MODE_O,
  input wire                      PULSE_CONNECT_O,
  input wire                      FIRST_SCALE_O,
  input wire                      FIRST_LOW_POWER_O,
  input wire [`LSD_SLEW_W-1:0]    FIRST_SLEW_O,
  input wire [`LSD_COARSE_W-1:0]  FIRST_COARSE_O,
  input wire                      THIRD_SCALE_O,
  input wire                      THIRD_LOW_POWER_O,
  input wire [`LSD_SLEW_W-1:0]    THIRD_SLEW_O,
  input wire [`LSD_COARSE_W-1:0]  THIRD_COARSE_O
);
  wire       wr_third = REG_WR_I && (REG_ADDR_I == 8'h22);
  wire       wr_first = REG_WR_I && (REG_ADDR_I == 8'h23);
  wire       in_slot  = SLOT_A_ACTIVE_I || SLOT_B_ACTIVE_I;
  wire [7:0] wd_f     = {REG_WDATA_I[13], REG_WDATA_I[6:0]};
  wire [7:0] third_f  = {THIRD_SCALE_O, THIRD_SLEW_O, THIRD_COARSE_O};
  wire [7:0] first_f  = {FIRST_SCALE_O, FIRST_SLEW_O, FIRST_COARSE_O};

  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);

  a_third_low_power: assert property (THIRD_LOW_POWER_O != THIRD_SCALE_O)
    else $error("third low power not inverse of scale");
  a_first_low_power: assert property (FIRST_LOW_POWER_O != FIRST_SCALE_O)
    else $error("first low power not inverse of scale");
  a_connect_cause: assert property (PULSE_CONNECT_O |-> FLOAT_MODE_O && $past(LED_PULSE_I))
    else $error("pulse connect without float and pulse");
  a_fire_cause: assert property (EMITTER_FIRE_O != 3'h0 |-> !FLOAT_MODE_O && $past(in_slot))
    else $error("emitter fired outside slot or in float");
  a_fire_onehot: assert property ($onehot0(EMITTER_FIRE_O))
    else $error("more than one emitter fired");
  a_third_write: assert property (wr_third |-> ##2 third_f == $past(wd_f, 2))
    else $error("third drive fields did not follow write");
  a_third_hold: assert property (!$past(wr_third, 2) |-> $stable(third_f))
    else $error("third drive fields moved without write");
  a_first_write: assert property (wr_first |-> ##2 first_f == $past(wd_f, 2))
    else $error("first drive fields did not follow write");
  a_first_hold: assert property (!$past(wr_first, 2) |-> $stable(first_f))
    else $error("first drive fields moved without write");
endmodule // lsd_monitor

//--- sim/tb.sv
`timescale 1ns/10ps

`include "lsd_regs.vh"

module tb;
  reg         CLK_SYS_I, RSTN_I, REG_WR_I, REG_RD_I, SLOT_A_ACTIVE_I, SLOT_B_ACTIVE_I, LED_PULSE_I;
  reg  [7:0]  REG_ADDR_I;
  reg  [15:0] REG_WDATA_I, m14, m22, m23, m25, fd;
  wire [15:0] REG_RDATA_O;
  wire [2:0]  EMITTER_FIRE_O, FIRST_SLEW_O, THIRD_SLEW_O;
  wire [3:0]  DIODE_ROUTE_O, FIRST_COARSE_O, THIRD_COARSE_O;
  wire        FLOAT_MODE_O, PULSE_CONNECT_O, FIRST_SCALE_O, FIRST_LOW_POWER_O;
  wire        THIRD_SCALE_O, THIRD_LOW_POWER_O;
  wire [26:0] FIRST_PEAK_O, THIRD_PEAK_O;
  integer     errors, n_checks, i, j, k;
  reg  [31:0] st, r;
  reg  [3:0]  route_x;
  reg  [1:0]  ch;

  lsd_top i_lsd_top (.*);

  always #4 CLK_SYS_I = ~CLK_SYS_I;

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function [31:0] xs();
    begin
      st = st ^ (st << 13);
      st = st ^ (st >> 17);
      st = st ^ (st << 5);
      xs = st;
    end
  endfunction

  function [26:0] pk(input [3:0] c, input [4:0] f, input s);
    pk = (27'h1F7 + 27'hC6 * c) * (27'h2E4 + 27'h16 * f) * (s ? 27'hA : 27'h1);
  endfunction

  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task tally_and_finish;
    begin
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  task wr(input [7:0] a, input [15:0] d);
    begin
      @(negedge CLK_SYS_I);
      REG_ADDR_I = a;
      REG_WDATA_I = d;
      REG_WR_I = 1'h1;
      @(negedge CLK_SYS_I);
      REG_WR_I = 1'h0;
    end
  endtask

  task rd(input [7:0] a, input [15:0] e);
    begin
      @(negedge CLK_SYS_I);
      REG_ADDR_I = a;
      REG_RD_I = 1'h1;
      @(negedge CLK_SYS_I);
      REG_RD_I = 1'h0;
      chk(REG_RDATA_O, e);
    end
  endtask

  task drv_chk;
    begin
      repeat (2) @(negedge CLK_SYS_I);
      chk({THIRD_SCALE_O, THIRD_LOW_POWER_O, THIRD_SLEW_O, THIRD_COARSE_O},
          {m22[13], !m22[13], m22[6:0]});
      chk(THIRD_PEAK_O, pk(m22[3:0], m25[15:11], m22[13]));
      chk({FIRST_SCALE_O, FIRST_LOW_POWER_O, FIRST_SLEW_O, FIRST_COARSE_O},
          {m23[13], !m23[13], m23[6:0]});
      chk(FIRST_PEAK_O, pk(m23[3:0], m25[15:11], m23[13]));
      rd(8'h22, m22);
      rd(8'h23, m23);
      rd(8'h25, m25);
    end
  endtask

  task slot(input a, input b, input p);
    begin
      @(negedge CLK_SYS_I);
      SLOT_A_ACTIVE_I = a;
      SLOT_B_ACTIVE_I = b;
      LED_PULSE_I = p;
      ch = a ? m14[1:0] : m14[3:2];
      if (a | b)
        route_x = a ? m14[7:4] : m14[11:8];
      @(negedge CLK_SYS_I);
      chk(EMITTER_FIRE_O, ((a | b) && p && ch != 2'h0) ? 3'h1 << (ch - 2'h1) : 3'h0);
      chk({FLOAT_MODE_O, PULSE_CONNECT_O},
          {(a | b) && ch == 2'h0, (a | b) && ch == 2'h0 && p});
      chk(DIODE_ROUTE_O, route_x);
    end
  endtask

  // ---------------------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------------------
  initial begin
    {CLK_SYS_I, RSTN_I, REG_WR_I, REG_RD_I, SLOT_A_ACTIVE_I, SLOT_B_ACTIVE_I, LED_PULSE_I} = 7'h0;
    REG_ADDR_I = 8'h00;
    REG_WDATA_I = 16'h0000;
    st = 32'h0000_157F;
    errors = 0;
    n_checks = 0;
    route_x = 4'h0;
    m14 = 16'h0541;
    m22 = 16'h3000;
    m23 = 16'h3000;
    m25 = 16'h6000;
    repeat (2) @(negedge CLK_SYS_I);
    RSTN_I = 1'h1;
    rd(8'h14, m14);
    drv_chk;
    wr(8'h30, 16'hFFFF);
    rd(8'h30, 16'h0000);
    rd(8'h14, m14);
    slot(1'h1, 1'h1, 1'h1);
    slot(1'h0, 1'h1, 1'h1);
    slot(1'h0, 1'h0, 1'h0);
    for (k = 0; k < 16; k = k + 1) begin
      // Both slots go idle first, so the routing output cannot pick up the new word during the write.
      slot(1'h0, 1'h0, 1'h0);
      r = xs();
      m14 = {4'h0, r[7:0], k[3:0]};
      wr(8'h14, m14);
      for (j = 0; j < 8; j = j + 1)
        slot(j[0], j[1], j[2]);
    end
    rd(8'h14, m14);
    for (i = 0; i < 40; i = i + 1) begin
      r = xs();
      fd = {2'h0, r[13], 1'h1, 5'h00, r[6:0]};
      if (r[17:16] == 2'h0) begin
        m25 = r[15:0];
        wr(8'h25, m25);
      end else if (r[16]) begin
        m22 = fd;
        wr(8'h22, m22);
      end else begin
        m23 = fd;
        wr(8'h23, m23);
      end
      drv_chk;
    end
    m22 = 16'h307F;
    m23 = 16'h1000;
    m25 = 16'hF800;
    wr(8'h22, m22);
    wr(8'h23, m23);
    wr(8'h25, m25);
    drv_chk;
    tally_and_finish;
  end

  initial begin
    #100000;
    errors = errors + 1;
    tally_and_finish;
  end
endmodule // tb

bind lsd_top lsd_monitor i_lsd_monitor (.*);
